// File: logic/reset_mgr_pkg.sv
// Package with register map, field layout and state types of the reset state manager.
package reset_mgr_pkg;
  localparam logic [3:0] OFF_COMMAND = 4'h0;
  localparam logic [3:0] OFF_STATUS  = 4'h4;
  localparam logic [3:0] OFF_MODE    = 4'h8;
  localparam logic [7:0] WRITE_KEY   = 8'hA5;
  localparam int KEY_LSB        = 24;
  localparam int CPU_CMD_BIT    = 0;
  localparam int PERIPH_CMD_BIT = 2;
  localparam int EXT_CMD_BIT    = 3;
  localparam int EDGE_BIT       = 0;
  localparam int CAUSE_LSB      = 8;
  localparam int LEVEL_BIT      = 16;
  localparam int BUSY_BIT       = 17;
  localparam int UREN_BIT       = 0;
  localparam int UIEN_BIT       = 4;
  localparam int LEN_LSB        = 8;
  localparam logic [2:0] CAUSE_GENERAL  = 3'h0;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER     = 3'h4;
  localparam logic [1:0] STATE_CYCLES   = 2'h2;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_SOFTWARE = 2'b01,
    ST_WATCHDOG = 2'b10,
    ST_USER     = 2'b11
  } rst_state_e;

  typedef struct packed {
    logic       cpu;
    logic       periph;
    logic       ext;
  } reset_lines_s;

  typedef struct packed {
    rst_state_e   state;
    logic [1:0]   cnt;
    logic [16:0]  ext_cnt;
    reset_lines_s act;
    logic         busy;
    logic [2:0]   cause;
    logic [2:0]   pend_cause;
    logic         cpu_in_cmd;
    logic         edge_flag;
    logic         ur_en;
    logic         ui_en;
    logic [3:0]   ext_len;
    logic [2:0]   pin_sync;
    logic [1:0]   slow_sync;
    logic [1:0]   wd_sync;
    logic [1:0]   wd_en_sync;
    logic [1:0]   cpu_only_sync;
    logic         slow_prev;
    logic         sw_ext_mask;
    logic         irq;
    logic         awvalid_seen;
    logic [3:0]   awaddr;
    logic         wvalid_seen;
    logic [31:0]  wdata;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } state_s;
endpackage

// File: logic/reset_state_manager_sw_wdt.sv
// Reset state manager for software, watchdog and user resets with an AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R01) Processor command resets processor and watchdog.
// (R02) Peripheral command resets all embedded peripherals.
// (R03) Software pairs peripheral with processor command.
// (R04) External command drives pin for length.
// (R05) Any command enters two-cycle software state.
// (R06) Assert at once, release on slow tick.
// (R07) Own external pulse never starts user reset.
// (R08) Cause records software only with processor.
// (R09) Busy flag blocks further command writes.
// (R10) Watchdog fault gives two-cycle watchdog state.
// (R11) Full watchdog: cpu, periph, external reset.
// (R12) Processor-only watchdog: processor reset alone.
// (R13) Watchdog reset disabled means fault ignored.
// (R14) Priority: watchdog, software, then user.
// (R15) Watchdog preempts software; pin ignored there.
// (R16) Level bit mirrors synchronised pin.
// (R17) Falling pin edge sets flag; read clears.
// (R18) Interrupt when flag, enable, no user reset.
// (R19) Cause field encodes type; read keeps it.
// (R20) Command and mode writes need key.
// (R21) External pulse lasts two power length-plus-one.
// (R22) User reset enable selects pin reset.
// (R23) Cause updates at processor reset release.
module reset_state_manager_sw_wdt (
  // Clock, reset and enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // Slow clock, watchdog and pin inputs from other domains.
  input  wire logic        slow_clk,
  input  wire logic        wd_fault,
  input  wire logic        wd_reset_enable,
  input  wire logic        wd_cpu_only,
  input  wire logic        ext_pin_in,
  // AXI4-Lite write channels.
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  // AXI4-Lite read channels.
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [3:0]  s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  // Reset and interrupt outputs, active high.
  output logic             cpu_reset,
  output logic             periph_reset,
  output logic             ext_pin_oe,
  output logic             ext_pin_out,
  output logic             irq
);

  // All state of the block lives in r_reg, one packed struct. The combinational process
  // below works out r_next from r_reg and the ports, and the clocked process registers it.
  // Keeping to that shape gives every field one driver and makes every output a flop.
  //
  // A command write is decoded one edge after both of its halves have been taken.
  // The write response and the selected reset lines rise at that same edge, so a master
  // that sees the response can rely on the reset already being asserted.
  // The processor and peripheral lines then stay up until the second slow tick that follows the write.
  //
  // The slow clock is never used as a clock here. It is sampled through two flops and
  // its rising edge becomes a one-cycle slow tick, and every duration counted in slow
  // cycles is counted in those ticks. The price is a few aclk cycles of lag behind the
  // true slow edge, which is small next to one slow period.
  //
  // The first slow tick after a command can come at any point of a slow period.
  // A two-cycle software state therefore lasts between one and two slow periods.
  // The same holds for the first cycle of the external pulse.
  //
  // The watchdog fault, its enable and the processor-only selector come from the slow
  // domain, so each has a two-flop synchroniser of its own. Gating the fault with the
  // enable ahead of the first flop would put logic in front of the synchroniser.
  //
  // The pin passes three flops. The first two synchronise it, and the third only serves
  // to find the falling edge, so the edge flag never sees an unsettled value.
  // A read of the status register clears the edge flag, but a falling edge seen in the
  // same cycle wins, so no edge is lost between two reads.
  //
  // A pulse that we drive onto the pin ourselves is masked from the user reset path
  // until the pin has been seen high again with our driver off. Without the mask, the
  // tail of our own pulse, delayed by the synchroniser, would start a user reset.
  //
  // Write strobes are ignored, so every register access is a full word.
  // A command written while the controller sits in watchdog or user reset is answered
  // but has no effect, because the processor is held in reset there anyway.
  // A command written while one is in progress is answered in the same way.
  //
  // The clock enable freezes every field at once, the synchronisers included.
  // A slow edge that comes and goes while frozen is missed, so keep frozen stretches short.

  reset_mgr_pkg::state_s r_reg;
  reset_mgr_pkg::state_s r_next;

  // Next state: bus slave, synchronisers, reset state machine and external pulse shaper.
  always_comb begin
    logic        slow_tick;
    logic        pin_lvl;
    logic        wd_evt;
    logic        wr_go;
    logic        rd_go;
    logic        key_ok;
    logic [2:0]  cmd;
    logic        rel;
    logic [16:0] ext_target;
    slow_tick  = 1'b0;
    pin_lvl    = 1'b0;
    wd_evt     = 1'b0;
    wr_go      = 1'b0;
    rd_go      = 1'b0;
    key_ok     = 1'b0;
    cmd        = 3'h0;
    rel        = 1'b0;
    ext_target = 17'h00000;
    r_next     = r_reg;

    // Two-flop synchronisers, three flops for the pin; logic reads the second stage, and the pin's third for its edge.
    r_next.pin_sync  = {r_reg.pin_sync[1:0], ext_pin_in};
    r_next.slow_sync = {r_reg.slow_sync[0], slow_clk};
    r_next.wd_sync       = {r_reg.wd_sync[0], wd_fault};
    r_next.wd_en_sync    = {r_reg.wd_en_sync[0], wd_reset_enable};
    r_next.cpu_only_sync = {r_reg.cpu_only_sync[0], wd_cpu_only};
    r_next.slow_prev = r_reg.slow_sync[1];
    slow_tick        = r_reg.slow_sync[1] & ~r_reg.slow_prev;
    pin_lvl          = r_reg.pin_sync[1];
    // The enable gates the fault only after both have been synchronised.
    wd_evt           = r_reg.wd_sync[1] & r_reg.wd_en_sync[1]; // [R13]

    // Write address and data are taken in either order.
    if (s_awvalid && !r_reg.awvalid_seen) begin
      r_next.awvalid_seen = 1'b1;
      r_next.awaddr       = s_awaddr;
    end
    if (s_wvalid && !r_reg.wvalid_seen) begin
      r_next.wvalid_seen = 1'b1;
      r_next.wdata       = s_wdata;
    end
    // A write is decoded only once both halves are held and no response is pending.
    wr_go  = r_reg.awvalid_seen && r_reg.wvalid_seen && !r_reg.bvalid;
    key_ok = (r_reg.wdata[reset_mgr_pkg::KEY_LSB +: 8] == reset_mgr_pkg::WRITE_KEY); // [R20]
    if (wr_go) begin
      r_next.awvalid_seen = 1'b0;
      r_next.wvalid_seen  = 1'b0;
      r_next.bvalid       = 1'b1;
      r_next.bresp        = reset_mgr_pkg::RESP_OKAY;
      if (r_reg.awaddr == reset_mgr_pkg::OFF_COMMAND) begin
        if (key_ok && !r_reg.busy) begin // [R09] [R20]
          cmd = {r_reg.wdata[reset_mgr_pkg::EXT_CMD_BIT],
                 r_reg.wdata[reset_mgr_pkg::PERIPH_CMD_BIT],
                 r_reg.wdata[reset_mgr_pkg::CPU_CMD_BIT]};
        end
      end else if (r_reg.awaddr == reset_mgr_pkg::OFF_MODE) begin
        if (key_ok) begin // [R20]
          r_next.ur_en   = r_reg.wdata[reset_mgr_pkg::UREN_BIT];
          r_next.ui_en   = r_reg.wdata[reset_mgr_pkg::UIEN_BIT];
          r_next.ext_len = r_reg.wdata[reset_mgr_pkg::LEN_LSB +: 4];
        end
      end else if (r_reg.awaddr != reset_mgr_pkg::OFF_STATUS) begin
        r_next.bresp = reset_mgr_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.bvalid && s_bready) begin
      r_next.bvalid = 1'b0;
    end

    // Falling pin edge sets the flag; set wins over the clearing read. [R17]
    // A read is answered one cycle after its address is taken.
    rd_go = s_arvalid && !r_reg.rvalid;
    if (rd_go) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = reset_mgr_pkg::RESP_OKAY;
      r_next.rdata  = 32'h00000000;
      if (s_araddr == reset_mgr_pkg::OFF_STATUS) begin
        r_next.rdata[reset_mgr_pkg::EDGE_BIT]       = r_reg.edge_flag;
        r_next.rdata[reset_mgr_pkg::CAUSE_LSB +: 3] = r_reg.cause; // [R19]
        r_next.rdata[reset_mgr_pkg::LEVEL_BIT]      = pin_lvl; // [R16]
        r_next.rdata[reset_mgr_pkg::BUSY_BIT]       = r_reg.busy;
        r_next.edge_flag                            = 1'b0; // [R17]
      end else if (s_araddr == reset_mgr_pkg::OFF_MODE) begin
        r_next.rdata[reset_mgr_pkg::UREN_BIT]     = r_reg.ur_en;
        r_next.rdata[reset_mgr_pkg::UIEN_BIT]     = r_reg.ui_en;
        r_next.rdata[reset_mgr_pkg::LEN_LSB +: 4] = r_reg.ext_len;
      end else if (s_araddr != reset_mgr_pkg::OFF_COMMAND) begin
        r_next.rresp = reset_mgr_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.rvalid && s_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (r_reg.pin_sync[2] && !pin_lvl) begin
      r_next.edge_flag = 1'b1; // [R17]
    end

    // Pulse on the pin lasts 2^(len+1) slow ticks, counted down from that figure. [R21]
    // Shifting two by the length avoids a four-bit length-plus-one that would wrap to zero at fifteen.
    // The widest pulse, at length fifteen, needs all seventeen counter bits.
    ext_target = 17'h00002 << r_reg.ext_len;
    if (r_reg.ext_cnt != 17'h00000 && slow_tick) begin
      r_next.ext_cnt = r_reg.ext_cnt - 17'h00001;
    end
    if (r_reg.ext_cnt == 17'h00001 && slow_tick) begin
      r_next.act.ext = 1'b0;
    end

    // Reset state machine; watchdog outranks software, software outranks user. [R14]
    case (r_reg.state)
      // Idle: a synchronised watchdog fault wins over a new command, and a command wins over the pin.
      reset_mgr_pkg::ST_IDLE: begin
        if (wd_evt) begin // [R10]
          r_next.state      = reset_mgr_pkg::ST_WATCHDOG;
          r_next.cnt        = reset_mgr_pkg::STATE_CYCLES;
          r_next.pend_cause = reset_mgr_pkg::CAUSE_WATCHDOG;
          r_next.act.cpu    = 1'b1; // [R12]
          r_next.act.periph = !r_reg.cpu_only_sync[1]; // [R11]
          if (!r_reg.cpu_only_sync[1]) begin
            r_next.act.ext     = 1'b1; // [R11]
            r_next.ext_cnt     = ext_target;
            r_next.sw_ext_mask = 1'b1;
          end
        end else if (cmd != 3'h0) begin // [R05]
          r_next.state      = reset_mgr_pkg::ST_SOFTWARE;
          r_next.cnt        = reset_mgr_pkg::STATE_CYCLES;
          r_next.busy       = 1'b1; // [R09]
          r_next.cpu_in_cmd = cmd[0]; // [R08]
          r_next.pend_cause = reset_mgr_pkg::CAUSE_SOFTWARE;
          r_next.act.cpu    = cmd[0]; // [R01] [R06]
          r_next.act.periph = cmd[1]; // [R02] [R06]
          if (cmd[2]) begin // [R04]
            r_next.act.ext     = 1'b1;
            r_next.ext_cnt     = ext_target;
            r_next.sw_ext_mask = 1'b1; // [R07]
          end
        end else if (r_reg.ur_en && !pin_lvl && !r_reg.sw_ext_mask && !r_reg.act.ext) begin // [R22] [R07]
          r_next.state      = reset_mgr_pkg::ST_USER;
          r_next.pend_cause = reset_mgr_pkg::CAUSE_USER;
          r_next.act.cpu    = 1'b1;
          r_next.act.periph = 1'b1;
        end else if (pin_lvl && !r_reg.act.ext) begin
          r_next.sw_ext_mask = 1'b0;
        end
      end

      // Software state: a watchdog fault takes over at once and the pin is not looked at.
      // The busy flag drops when the state is left either way, so software may retry.
      reset_mgr_pkg::ST_SOFTWARE: begin
        if (wd_evt) begin // [R15]
          r_next.state      = reset_mgr_pkg::ST_WATCHDOG;
          r_next.cnt        = reset_mgr_pkg::STATE_CYCLES;
          r_next.busy       = 1'b0;
          r_next.pend_cause = reset_mgr_pkg::CAUSE_WATCHDOG;
          r_next.act.cpu    = 1'b1;
          r_next.act.periph = !r_reg.cpu_only_sync[1];
          if (!r_reg.cpu_only_sync[1]) begin
            r_next.act.ext     = 1'b1;
            r_next.ext_cnt     = ext_target;
            r_next.sw_ext_mask = 1'b1;
          end
        end else if (slow_tick) begin
          r_next.cnt = r_reg.cnt - 2'h1;
          if (r_reg.cnt == 2'h1) begin // [R05] [R06]
            r_next.state      = reset_mgr_pkg::ST_IDLE;
            r_next.busy       = 1'b0; // [R09]
            r_next.act.cpu    = 1'b0;
            r_next.act.periph = 1'b0;
            rel               = r_reg.cpu_in_cmd; // [R08]
          end
        end
      end

      // Watchdog state: nothing can preempt it, and the cause is always reported on release.
      // A command written here is answered but ignored, as the processor is held in reset anyway.
      reset_mgr_pkg::ST_WATCHDOG: begin
        if (slow_tick) begin
          r_next.cnt = r_reg.cnt - 2'h1;
          if (r_reg.cnt == 2'h1) begin // [R10]
            r_next.state      = reset_mgr_pkg::ST_IDLE;
            r_next.act.cpu    = 1'b0;
            r_next.act.periph = 1'b0;
            rel               = 1'b1;
          end
        end
      end

      // Any code left over is the user state.
      default: begin
        // User reset holds until the pin is high and our own pulse is over.
        if (pin_lvl && !r_reg.act.ext && slow_tick) begin
          r_next.state      = reset_mgr_pkg::ST_IDLE;
          r_next.act.cpu    = 1'b0;
          r_next.act.periph = 1'b0;
          rel               = 1'b1;
        end
      end
    endcase
    if (rel) begin
      r_next.cause = r_reg.pend_cause; // [R23]
    end

    // Interrupt only stands in for the reset when user reset is disabled. [R18]
    r_next.irq = r_next.edge_flag && r_reg.ui_en && !r_reg.ur_en;
  end

  // State register; the clock enable freezes everything.
  // Reset is synchronous, and its branch assigns constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg       <= '0;
      r_reg.cause <= reset_mgr_pkg::CAUSE_GENERAL;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  // The ready signals are inverted flag bits, so they too come from flops and never from a bus input.
  // The pin is only ever pulled low; its level while driven is fixed.
  always_comb begin
    s_awready    = !r_reg.awvalid_seen;
    s_wready     = !r_reg.wvalid_seen;
    s_bvalid     = r_reg.bvalid;
    s_bresp      = r_reg.bresp;
    s_arready    = !r_reg.rvalid;
    s_rvalid     = r_reg.rvalid;
    s_rdata      = r_reg.rdata;
    s_rresp      = r_reg.rresp;
    cpu_reset    = r_reg.act.cpu;
    periph_reset = r_reg.act.periph;
    ext_pin_oe   = r_reg.act.ext;
    ext_pin_out  = 1'b0;
    irq          = r_reg.irq;
  end

endmodule
`default_nettype wire

// File: testbench/reset_mgr_sva.sv
// Checker with timing assertions on the reset state manager ports.
`timescale 1ns/10ps
`default_nettype none
module reset_mgr_sva (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Watched inputs and outputs.
  input wire logic slow_clk,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic wd_fault,
  input wire logic wd_reset_enable,
  input wire logic cpu_reset,
  input wire logic ext_pin_oe,
  input wire logic ext_pin_out
);
  logic       slow_q;
  logic [3:0] since;
  // Cycles since the last slow clock rise; it saturates so a stopped clock never wraps it.
  always_ff @(posedge aclk) begin
    slow_q <= slow_clk;
    since  <= (slow_clk && !slow_q) ? 4'h0 : ((since == 4'hF) ? since : since + 4'h1);
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ext_drive_low: assert property (ext_pin_oe |-> !ext_pin_out)
    else $error("pin enabled but not driven low");
  a_ext_min_len: assert property ($rose(ext_pin_oe) |-> ext_pin_oe[*8])
    else $error("external pulse too short");
  a_cpu_min_len: assert property ($rose(cpu_reset) |-> cpu_reset[*8])
    else $error("processor reset too short");
  a_release_on_tick: assert property ($fell(cpu_reset) |-> since <= 4'h6)
    else $error("processor reset released away from a slow tick");
  a_wd_fault_reset: assert property (
    (wd_reset_enable && wd_fault && !cpu_reset) ##1 (wd_reset_enable && wd_fault)[*2] |-> ##[0:4] cpu_reset)
    else $error("watchdog fault gave no processor reset");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered in one cycle");
  a_read_single: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answered twice");
  a_write_single: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("write answered twice");
endmodule
bind reset_state_manager_sw_wdt reset_mgr_sva i_reset_mgr_sva (.aclk, .aresetn, .slow_clk, .s_arvalid,
  .s_arready, .s_rvalid, .s_rready, .s_bvalid, .s_bready, .wd_fault, .wd_reset_enable, .cpu_reset,
  .ext_pin_oe, .ext_pin_out);
`default_nettype wire

// File: testbench/reset_far_side.sv
// Far-side model: slow clock, watchdog and the pulled-up reset pin.
`timescale 1ns/10ps
`default_nettype none
module reset_far_side (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench controls.
  input  wire logic wd_trip,
  input  wire logic user_low,
  // Device side.
  input  wire logic cpu_reset,
  input  wire logic ext_pin_oe,
  input  wire logic ext_pin_out,
  output logic      slow_clk,
  output logic      wd_fault,
  output logic      ext_pin_in
);
  logic [3:0] div;
  // Slow clock is a sixteenth of aclk; the watchdog is held cleared while the processor is in reset.
  always_ff @(posedge aclk) begin
    div      <= aresetn ? div + 4'h1 : 4'h0;
    wd_fault <= wd_trip && !cpu_reset && aresetn;
  end
  assign slow_clk = div[3];
  // The pin is pulled up, so it reads high unless the device or a button pulls it low.
  assign ext_pin_in = !(ext_pin_oe && !ext_pin_out) && !user_low;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the reset state manager.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int SLOW = 16;
  localparam logic [3:0] CMD = reset_mgr_pkg::OFF_COMMAND;
  localparam logic [3:0] MODE = reset_mgr_pkg::OFF_MODE;
  logic        aclk, aresetn, wd_reset_enable, wd_cpu_only, wd_trip, user_low, slow_clk, wd_fault;
  logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
  logic        s_arready, s_rvalid, ext_pin_in, cpu_reset, periph_reset, ext_pin_oe, ext_pin_out, irq;
  logic [3:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, v, rd;
  logic [1:0]  s_bresp, s_rresp, r;
  int          fails, checks_done, cyc, n, len;
  reset_state_manager_sw_wdt i_reset_state_manager_sw_wdt (.aclk, .aresetn, .clk_en(1'b1), .slow_clk,
    .wd_fault, .wd_reset_enable, .wd_cpu_only, .ext_pin_in, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb(4'hF), .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
    .s_rvalid, .s_rready, .s_rdata, .s_rresp, .cpu_reset, .periph_reset, .ext_pin_oe, .ext_pin_out, .irq);
  reset_far_side i_reset_far_side (.aclk, .aresetn, .wd_trip, .user_low, .cpu_reset, .ext_pin_oe,
    .ext_pin_out, .slow_clk, .wd_fault, .ext_pin_in);
  // Mode readback keeps only the defined fields.
  function automatic logic [31:0] exp_mode(input logic [31:0] d);
    return d & 32'h00000F11;
  endfunction
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // Both write channels are offered together and each is dropped when taken.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      r = s_bresp;
    end while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      d = s_rdata;
      r = s_rresp;
    end while (!s_rvalid);
    s_rready <= 1'b0;
  endtask
  // Waits out every reset line, then lets the pin synchroniser catch up.
  task automatic settle();
    do @(posedge aclk); while (cpu_reset || periph_reset || ext_pin_oe);
    repeat (8) @(posedge aclk);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // A hang is cut short well beyond the several hundred cycles the tests need.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    {aresetn, wd_reset_enable, wd_cpu_only, wd_trip, user_low} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {fails, checks_done, cyc} = '0;
    void'($urandom(60));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(4'h4, v);
    cmp_word(v & 32'h00030700, 32'h00010000);
    v = $urandom;
    axi_wr(MODE, {8'hA5, v[23:0]});
    cmp_word({30'h0, r}, {30'h0, reset_mgr_pkg::RESP_OKAY});
    axi_rd(MODE, rd);
    cmp_word(rd, exp_mode(v));
    axi_wr(MODE, {v[31:24] | 8'h01, ~v[23:0]} ^ 32'hA5000000);
    axi_wr(CMD, 32'h5A000001);
    axi_rd(MODE, rd);
    cmp_word(rd, exp_mode(v));
    cmp_bit(cpu_reset, 1'b0);
    axi_wr(4'hC, 32'hA5000001);
    cmp_word({30'h0, r}, {30'h0, reset_mgr_pkg::RESP_SLVERR});
    axi_rd(4'hC, rd);
    cmp_word({30'h0, r}, {30'h0, reset_mgr_pkg::RESP_SLVERR});
    $display("register test done");
    // Watchdog in full and processor-only form, user reset enabled.
    axi_wr(MODE, 32'hA5000001);
    wd_reset_enable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wd_cpu_only <= k[0];
      wd_trip     <= 1'b1;
      for (n = 0; n < 40 && !cpu_reset; n++) @(posedge aclk);
      wd_trip <= 1'b0;
      repeat (4) @(posedge aclk);
      cmp_bit(periph_reset, !k[0]);
      cmp_bit(ext_pin_oe, !k[0]);
      settle();
      axi_rd(4'h4, v);
      cmp_word(v & 32'h700, 32'h200);
    end
    wd_reset_enable <= 1'b0;
    wd_trip         <= 1'b1;
    repeat (40) @(posedge aclk);
    cmp_bit(cpu_reset, 1'b0);
    wd_trip         <= 1'b0;
    $display("watchdog test done");
    // Peripheral-only and external-only commands, with the pin pulled low meanwhile.
    len = $urandom_range(2);
    axi_wr(MODE, 32'hA5000001 | (len << 8));
    for (int k = 2; k < 4; k++) begin
      axi_wr(CMD, 32'hA5000000 | (1 << k));
      cmp_bit(periph_reset, k == 2);
      if (k == 2) begin
        user_low <= 1'b1;
        repeat (10) @(posedge aclk);
        user_low <= 1'b0;
      end else begin
        for (n = 0; n < 8 && !ext_pin_oe; n++) @(posedge aclk);
        for (n = 0; n < 2000 && ext_pin_oe; n++) @(posedge aclk);
        cmp_bit(n >= (2 << len) * SLOW - SLOW && n <= (2 << len) * SLOW + 8, 1'b1);
      end
      settle();
      axi_rd(4'h4, v);
      cmp_word(v & 32'h20700, 32'h200);
    end
    // Processor and peripheral together; a second command while busy is dropped.
    axi_wr(CMD, 32'hA5000005);
    cmp_bit(cpu_reset, 1'b1);
    cmp_bit(periph_reset, 1'b1);
    axi_wr(CMD, 32'hA5000008);
    axi_rd(4'h4, v);
    cmp_bit(v[reset_mgr_pkg::BUSY_BIT], 1'b1);
    for (n = 6; n < 200 && cpu_reset; n++) @(posedge aclk);
    cmp_bit(n >= SLOW && n <= 2 * SLOW + 8, 1'b1);
    cmp_bit(ext_pin_oe, 1'b0);
    settle();
    axi_rd(4'h4, v);
    cmp_word(v & 32'h20700, 32'h300);
    axi_wr(CMD, 32'hA5000004);
    wd_reset_enable <= 1'b1;
    wd_trip         <= 1'b1;
    for (n = 0; n < 40 && !cpu_reset; n++) @(posedge aclk);
    wd_trip <= 1'b0;
    settle();
    axi_rd(4'h4, v);
    cmp_word(v & 32'h700, 32'h200);
    $display("software test done");
    // Pin edge as an interrupt, then as a user reset.
    axi_rd(4'h4, v);
    axi_wr(MODE, 32'hA5000010);
    user_low <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp_bit(irq, 1'b1);
    axi_rd(4'h4, v);
    cmp_word(v & 32'h10001, 32'h1);
    user_low <= 1'b0;
    repeat (8) @(posedge aclk);
    cmp_bit(irq, 1'b0);
    axi_rd(4'h4, v);
    cmp_word(v & 32'h10001, 32'h10000);
    axi_wr(MODE, 32'hA5000011);
    user_low <= 1'b1;
    for (n = 0; n < 40 && !cpu_reset; n++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    cmp_bit(periph_reset, 1'b1);
    cmp_bit(irq, 1'b0);
    user_low <= 1'b0;
    settle();
    axi_rd(4'h4, v);
    cmp_word(v & 32'h700, 32'h400);
    $display("user test done");
    final_report();
  end
endmodule
`default_nettype wire
